// ---- design/tto_consts.svh ----
// Purpose: constants of the twilight threshold output stage
// Assumes: included by its bare name from the design, the checker and the bench
// Notes:   offsets, fields, reset values, source codes, lux figures and timing counts only
`ifndef TTO_CONSTS_SVH
`define TTO_CONSTS_SVH

// register offsets (word index on the register port)
`define TTO_REG_CTRL     4'h0
`define TTO_REG_LEVEL    4'h1
`define TTO_REG_HYST     4'h2
`define TTO_REG_DELAY    4'h3
`define TTO_REG_CYCLE    4'h4
`define TTO_REG_EXT16    4'h5
`define TTO_REG_EXT8     4'h6
`define TTO_REG_STATUS   4'h7

// control fields
`define TTO_CTRL_BOTH    0
`define TTO_CTRL_MODE_LO 1
`define TTO_CTRL_MODE_HI 4
`define TTO_CTRL_EXT_LO  5
`define TTO_CTRL_EXT_HI  6
`define TTO_CTRL_SOC2    7
`define TTO_CTRL_SOC1    8

// delay register fields
`define TTO_DLY_ON2_LO   0
`define TTO_DLY_ON2_HI   3
`define TTO_DLY_OFF2_LO  4
`define TTO_DLY_OFF2_HI  7
`define TTO_DLY_OFF1_LO  8
`define TTO_DLY_OFF1_HI  11

// reset values
`define TTO_CTRL_RST     9'h000
`define TTO_LEVEL_RST    5'h00
`define TTO_HYST_RST     4'h0
`define TTO_DELAY_RST    12'h000
`define TTO_CYCLE_RST    7'h00

// external threshold source
`define TTO_EXT_NONE     2'h0
`define TTO_EXT_16       2'h1
`define TTO_EXT_8        2'h2

// lux figures
`define TTO_LVL_FIRST    16'h000A
`define TTO_LVL_STEP     16'h0019
`define TTO_HYST_A       16'h0005
`define TTO_HYST_B       16'h000A
`define TTO_HYST_C       16'h0019
`define TTO_HYST_STEP    16'h0032
`define TTO_RANGE_LUX    18'h002A2
`define TTO_PCT_FULL     18'h00064

// timing
`define TTO_CLK_HZ       125000000
`define TTO_TICK_S       1
`define TTO_TICK_CYCLES  (`TTO_TICK_S * `TTO_CLK_HZ)
`define TTO_CYC_UNIT_S   11'h00A

`endif

// ---- design/tto_pkg.sv ----
// Purpose: types of the twilight threshold output stage
// Assumes: constants come from tto_consts.svh
// Notes:   no logic here
`default_nettype none
package tto_pkg;
   typedef enum logic [1:0] {
      TTO_ACT_NONE,
      TTO_ACT_ON,
      TTO_ACT_OFF
   } tto_act_t;

   typedef enum logic [1:0] {
      TTO_DLY_IDLE,
      TTO_DLY_ON_WAIT,
      TTO_DLY_OFF_WAIT
   } tto_dly_state_t;

   typedef logic [3:0]  tto_addr_t;
   typedef logic [15:0] tto_word_t;
endpackage : tto_pkg
`default_nettype wire

// ---- design/tto_threshold_out.sv ----
// Purpose: second twilight threshold with hysteresis, delays and telegram output
// Assumes: lux_value is integer lux on core_clk; registers on a plain port
// Notes:   tx_valid is a one-cycle telegram request carrying tx_value
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`include "tto_consts.svh"
`default_nettype none

// Operation
// RQ1 - threshold two works only when enabled
// RQ2 - level 10 lux, then 25 to 650
// RQ3 - hysteresis none,5,10,25, then 50..600
// RQ4 - exceed modes: above on, below minus hyst
// RQ5 - undershoot modes: below on, above plus hyst
// RQ6 - twelve modes, some directions send nothing
// RQ7 - no-telegram condition also mutes cyclic sends
// RQ8 - external 16-bit threshold from 2-byte object
// RQ9 - external 8-bit threshold, else configured level
// RQ10 - switch-on delay fourteen choices
// RQ11 - switch-off delay same choices, per threshold
// RQ12 - ON accepted only after on delay
// RQ13 - OFF accepted only after off delay
// RQ14 - send on change when enabled
// RQ15 - no change send when disabled
// RQ16 - cyclic send when setting nonzero
// RQ17 - cyclic period is setting times ten
// RQ18 - zero setting disables cyclic sending
// RQ19 - 8-bit value is percent of 674
// RQ20 - configuration drops external value until new
// RQ21 - one-second tick from clock prescaler
// RQ22 - reset: output 0, timers idle, cycle restarted
// RQ23 - return to accepted state cancels delay
module tto_threshold_out #(
   parameter int TICK_CYCLES = `TTO_TICK_CYCLES
) (
   input  wire  logic               core_clk,
   input  wire  logic               srst,
   input  wire  tto_pkg::tto_addr_t reg_addr,
   input  wire  tto_pkg::tto_word_t reg_wdata,
   input  wire  logic               reg_wr,
   input  wire  logic               reg_rd,
   output var   tto_pkg::tto_word_t reg_rdata,
   input  wire  logic [15:0]        lux_value,
   output var   logic               tx_valid,
   output var   logic               tx_value
);
   import tto_pkg::*;

   logic [8:0]     ctrl_reg;
   logic [4:0]     level_reg;
   logic [3:0]     hyst_reg;
   logic [11:0]    delay_reg;
   logic [6:0]     cycle_reg;
   logic [15:0]    ext_val_reg;
   logic           ext_seen_reg;
   logic [26:0]    tick_cnt_reg;
   logic           tick;
   logic           cond_reg;
   logic           acc_reg;
   logic           acc_d_reg;
   tto_dly_state_t dly_state_reg;
   logic [11:0]    dly_cnt_reg;
   logic [10:0]    cyc_cnt_reg;
   logic [10:0]    period;
   logic           cyc_fire;
   logic           enable;
   logic [3:0]     mode;
   logic [1:0]     ext_mode;
   logic [15:0]    thr;
   logic [16:0]    thr_hi;
   logic [16:0]    lux_hi;
   logic [15:0]    hyst;
   tto_act_t       cur_act;
   logic           raw;
   logic           suppress;
   logic [11:0]    on_s;
   logic [11:0]    off_s;
   logic [17:0]    pct_prod;
   logic [4:0]     level_wr;
   logic [6:0]     cycle_wr;

   // configured level in lux
   function automatic logic [15:0] level_lux(input logic [4:0] idx);
      if (idx == 5'h00) begin
         level_lux = `TTO_LVL_FIRST;
      end else begin
         level_lux = {11'h000, idx} * `TTO_LVL_STEP;
      end
   endfunction : level_lux

   // hysteresis band in lux
   function automatic logic [15:0] hyst_lux(input logic [3:0] idx);
      case (idx)
         4'h0: hyst_lux = 16'h0000;
         4'h1: hyst_lux = `TTO_HYST_A;
         4'h2: hyst_lux = `TTO_HYST_B;
         4'h3: hyst_lux = `TTO_HYST_C;
         default: hyst_lux = {12'h000, idx - 4'h3} * `TTO_HYST_STEP;
      endcase
   endfunction : hyst_lux

   // delay choice in seconds
   function automatic logic [11:0] delay_s(input logic [3:0] idx);
      case (idx)
         4'h0: delay_s = 12'h000;
         4'h1: delay_s = 12'h001;
         4'h2: delay_s = 12'h003;
         4'h3: delay_s = 12'h005;
         4'h4: delay_s = 12'h00A;
         4'h5: delay_s = 12'h00F;
         4'h6: delay_s = 12'h01E;
         4'h7: delay_s = 12'h03C;
         4'h8: delay_s = 12'h0B4;
         4'h9: delay_s = 12'h12C;
         4'hA: delay_s = 12'h258;
         4'hB: delay_s = 12'h384;
         4'hC: delay_s = 12'h708;
         4'hD: delay_s = 12'hE10;
         default: delay_s = 12'h000;
      endcase
   endfunction : delay_s

   // action of a mode: fulfilled side when set_side, else return side
   function automatic tto_act_t act_of(input logic [3:0] m, input logic set_side);
      act_of = TTO_ACT_NONE;
      case (m)
         4'h0, 4'h2: act_of = set_side ? TTO_ACT_ON : TTO_ACT_OFF;
         4'h1, 4'h3: act_of = set_side ? TTO_ACT_OFF : TTO_ACT_ON;
         4'h4, 4'h6: act_of = set_side ? TTO_ACT_ON : TTO_ACT_NONE;
         4'h5, 4'h7: act_of = set_side ? TTO_ACT_OFF : TTO_ACT_NONE;
         4'h8, 4'hA: act_of = set_side ? TTO_ACT_NONE : TTO_ACT_OFF;
         4'h9, 4'hB: act_of = set_side ? TTO_ACT_NONE : TTO_ACT_ON;
         default: act_of = TTO_ACT_NONE;
      endcase
   endfunction : act_of

   assign enable   = ctrl_reg[`TTO_CTRL_BOTH];
   assign mode     = ctrl_reg[`TTO_CTRL_MODE_HI:`TTO_CTRL_MODE_LO];
   assign ext_mode = ctrl_reg[`TTO_CTRL_EXT_HI:`TTO_CTRL_EXT_LO];
   assign on_s     = delay_s(delay_reg[`TTO_DLY_ON2_HI:`TTO_DLY_ON2_LO]);   // see RQ10
   assign off_s    = delay_s(delay_reg[`TTO_DLY_OFF2_HI:`TTO_DLY_OFF2_LO]); // see RQ11
   assign hyst     = hyst_lux(hyst_reg);                                     // see RQ3
   assign pct_prod = {10'h000, reg_wdata[7:0]} * `TTO_RANGE_LUX;              // see RQ19

   // write clamps judge the whole word
   assign level_wr = (reg_wdata > 16'h001A) ? 5'h1A : reg_wdata[4:0];        // see RQ2
   assign cycle_wr = (reg_wdata > 16'h0078) ? 7'h78 : reg_wdata[6:0];        // see RQ17

   // configuration registers
   always_ff @(posedge core_clk) begin
      if (srst) begin
         ctrl_reg  <= `TTO_CTRL_RST;
         level_reg <= `TTO_LEVEL_RST;
         hyst_reg  <= `TTO_HYST_RST;
         delay_reg <= `TTO_DELAY_RST;
         cycle_reg <= `TTO_CYCLE_RST;
      end else if (reg_wr) begin
         case (reg_addr)
            `TTO_REG_CTRL:  ctrl_reg  <= reg_wdata[8:0];
            `TTO_REG_LEVEL: level_reg <= level_wr; // see RQ2
            `TTO_REG_HYST:  hyst_reg  <= reg_wdata[3:0];
            `TTO_REG_DELAY: delay_reg <= reg_wdata[11:0];
            `TTO_REG_CYCLE: cycle_reg <= cycle_wr; // see RQ17
            default: ;
         endcase
      end
   end

   // external threshold objects
   always_ff @(posedge core_clk) begin
      if (srst) begin
         ext_val_reg  <= 16'h0000;
         ext_seen_reg <= 1'b0;
      end else if (reg_wr && reg_addr == `TTO_REG_CTRL) begin
         ext_seen_reg <= 1'b0; // see RQ20
      end else if (reg_wr && reg_addr == `TTO_REG_EXT16 && ext_mode == `TTO_EXT_16) begin
         ext_val_reg  <= reg_wdata; // see RQ8
         ext_seen_reg <= 1'b1;
      end else if (reg_wr && reg_addr == `TTO_REG_EXT8 && ext_mode == `TTO_EXT_8) begin
         ext_val_reg  <= 16'(pct_prod / `TTO_PCT_FULL); // see RQ9
         ext_seen_reg <= 1'b1;
      end
   end

   // effective threshold: external once received, else configured
   always_comb begin
      if (ext_seen_reg && ext_mode != `TTO_EXT_NONE) begin
         thr = ext_val_reg; // see RQ8
      end else begin
         thr = level_lux(level_reg); // see RQ9
      end
   end

   // one-second time base
   always_ff @(posedge core_clk) begin
      if (srst || tick) begin
         tick_cnt_reg <= 27'h0000000;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 27'h0000001;
      end
   end

   assign tick = (tick_cnt_reg == 27'(TICK_CYCLES - 1)); // see RQ21

   // crossing condition with hysteresis
   always_comb begin
      thr_hi = {1'b0, thr} + {1'b0, hyst};
      lux_hi = {1'b0, lux_value} + {1'b0, hyst};
   end

   always_ff @(posedge core_clk) begin
      if (srst || !enable) begin
         cond_reg <= 1'b0;
      end else if (!mode[1]) begin
         if (lux_value > thr) begin
            cond_reg <= 1'b1; // see RQ4
         end else if (lux_hi < {1'b0, thr}) begin
            cond_reg <= 1'b0; // see RQ4
         end
      end else begin
         if (lux_value < thr) begin
            cond_reg <= 1'b1; // see RQ5
         end else if ({1'b0, lux_value} > thr_hi) begin
            cond_reg <= 1'b0; // see RQ5
         end
      end
   end

   // wanted level from the mode's action
   always_comb begin
      cur_act  = act_of(mode, cond_reg); // see RQ6
      suppress = (cur_act == TTO_ACT_NONE); // see RQ7
      case (cur_act)
         TTO_ACT_ON:  raw = 1'b1;
         TTO_ACT_OFF: raw = 1'b0;
         default:     raw = acc_reg;
      endcase
   end

   // acceptance delays
   always_ff @(posedge core_clk) begin
      if (srst || !enable) begin
         dly_state_reg <= TTO_DLY_IDLE; // see RQ22
         dly_cnt_reg   <= 12'h000;
         acc_reg       <= 1'b0; // see RQ1
      end else begin
         case (dly_state_reg)
            TTO_DLY_IDLE: begin
               if (raw && !acc_reg) begin
                  if (on_s == 12'h000) begin
                     acc_reg <= 1'b1;
                  end else begin
                     dly_state_reg <= TTO_DLY_ON_WAIT; // see RQ12
                     dly_cnt_reg   <= on_s;
                  end
               end else if (!raw && acc_reg) begin
                  if (off_s == 12'h000) begin
                     acc_reg <= 1'b0;
                  end else begin
                     dly_state_reg <= TTO_DLY_OFF_WAIT; // see RQ13
                     dly_cnt_reg   <= off_s;
                  end
               end
            end
            TTO_DLY_ON_WAIT: begin
               if (!raw) begin
                  dly_state_reg <= TTO_DLY_IDLE; // see RQ23
               end else if (tick) begin
                  if (dly_cnt_reg == 12'h001) begin
                     acc_reg       <= 1'b1; // see RQ12
                     dly_state_reg <= TTO_DLY_IDLE;
                  end
                  dly_cnt_reg <= dly_cnt_reg - 12'h001;
               end
            end
            TTO_DLY_OFF_WAIT: begin
               if (raw) begin
                  dly_state_reg <= TTO_DLY_IDLE; // see RQ23
               end else if (tick) begin
                  if (dly_cnt_reg == 12'h001) begin
                     acc_reg       <= 1'b0; // see RQ13
                     dly_state_reg <= TTO_DLY_IDLE;
                  end
                  dly_cnt_reg <= dly_cnt_reg - 12'h001;
               end
            end
            default: begin
               dly_state_reg <= TTO_DLY_IDLE;
            end
         endcase
      end
   end

   // cyclic repeat timer
   assign period   = 11'(cycle_reg) * `TTO_CYC_UNIT_S; // see RQ17
   assign cyc_fire = tick && (period != 11'h000) && (cyc_cnt_reg <= 11'h001); // see RQ18

   always_ff @(posedge core_clk) begin
      if (srst) begin
         cyc_cnt_reg <= 11'h000; // see RQ22
      end else if (reg_wr && reg_addr == `TTO_REG_CYCLE) begin
         cyc_cnt_reg <= 11'(cycle_wr) * `TTO_CYC_UNIT_S;
      end else if (cyc_fire) begin
         cyc_cnt_reg <= period; // see RQ16
      end else if (tick && cyc_cnt_reg != 11'h000) begin
         cyc_cnt_reg <= cyc_cnt_reg - 11'h001;
      end
   end

   // telegram output
   always_ff @(posedge core_clk) begin
      if (srst) begin
         acc_d_reg <= 1'b0;
         tx_valid  <= 1'b0;
         tx_value  <= 1'b0;
      end else begin
         acc_d_reg <= acc_reg;
         tx_value  <= acc_reg;
         // see RQ14, RQ15, RQ16, RQ7
         tx_valid  <= enable && (((acc_reg != acc_d_reg) && ctrl_reg[`TTO_CTRL_SOC2])
                                 || (cyc_fire && !suppress));
      end
   end

   // register read port
   always_ff @(posedge core_clk) begin
      if (srst || !reg_rd) begin
         reg_rdata <= 16'h0000;
      end else begin
         case (reg_addr)
            `TTO_REG_CTRL:   reg_rdata <= {7'h00, ctrl_reg};
            `TTO_REG_LEVEL:  reg_rdata <= {11'h000, level_reg};
            `TTO_REG_HYST:   reg_rdata <= {12'h000, hyst_reg};
            `TTO_REG_DELAY:  reg_rdata <= {4'h0, delay_reg};
            `TTO_REG_CYCLE:  reg_rdata <= {9'h000, cycle_reg};
            `TTO_REG_EXT16:  reg_rdata <= thr;
            `TTO_REG_STATUS: reg_rdata <= {10'h000, ext_seen_reg, suppress,
                                           dly_state_reg == TTO_DLY_OFF_WAIT,
                                           dly_state_reg == TTO_DLY_ON_WAIT,
                                           cond_reg, acc_reg};
            default:         reg_rdata <= 16'h0000;
         endcase
      end
   end
endmodule : tto_threshold_out
`default_nettype wire

// ---- tb/tto_threshold_out_chk.sv ----
// Purpose: port checker for the threshold output stage
// Assumes: bound to tto_threshold_out, one clock domain
// Notes:   shadows enable, send-on-change and cycle setting from writes
`include "tto_consts.svh"
`default_nettype none
module tto_threshold_out_chk (
   input wire logic               core_clk,
   input wire logic               srst,
   input wire tto_pkg::tto_addr_t reg_addr,
   input wire tto_pkg::tto_word_t reg_wdata,
   input wire logic               reg_wr,
   input wire logic               reg_rd,
   input wire tto_pkg::tto_word_t reg_rdata,
   input wire logic [15:0]        lux_value,
   input wire logic               tx_valid,
   input wire logic               tx_value
);
   timeunit 1ns;
   timeprecision 1ps;
   import tto_pkg::*;
   logic en_reg;
   logic soc_reg;
   logic cyc_reg;
   always_ff @(posedge core_clk) begin
      if (srst) begin
         en_reg  <= 1'b0;
         soc_reg <= 1'b0;
      end else if (reg_wr && reg_addr == `TTO_REG_CTRL) begin
         en_reg  <= reg_wdata[`TTO_CTRL_BOTH];
         soc_reg <= reg_wdata[`TTO_CTRL_SOC2];
      end
   end
   always_ff @(posedge core_clk) begin
      if (srst) begin
         cyc_reg <= 1'b0;
      end else if (reg_wr && reg_addr == `TTO_REG_CYCLE) begin
         cyc_reg <= |reg_wdata;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);
   sequence s_rd(a);
      reg_rd && reg_addr == a ##1 1'b1;
   endsequence
   sequence s_off;
      !en_reg [*3];
   endsequence
   sequence s_quiet;
      (!soc_reg && !cyc_reg) [*3];
   endsequence
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data not zero outside read cycle");
   a_reset_quiet: assert property ($fell(srst) |-> !tx_valid && !tx_value)
      else $error("telegram output not idle after reset");
   a_level_clamp: assert property (s_rd(`TTO_REG_LEVEL) |-> reg_rdata <= 16'h001A)
      else $error("level index above 650 lux");
   a_hyst_width: assert property (s_rd(`TTO_REG_HYST) |-> reg_rdata[15:4] == 12'h000)
      else $error("hysteresis index too wide");
   a_cycle_clamp: assert property (s_rd(`TTO_REG_CYCLE) |-> reg_rdata <= 16'h0078)
      else $error("cycle setting above 120");
   a_delay_width: assert property (s_rd(`TTO_REG_DELAY) |-> reg_rdata[15:12] == 4'h0)
      else $error("delay register too wide");
   a_disabled_mute: assert property (s_off |-> !tx_valid && !tx_value)
      else $error("telegram while threshold two disabled");
   a_never_sent: assert property (s_quiet |-> !tx_valid)
      else $error("telegram with both send paths off");
   a_change_send: assert property ($changed(tx_value) && soc_reg && $past(soc_reg)
      && en_reg && $past(en_reg) |-> tx_valid)
      else $error("accepted change without telegram");
endmodule : tto_threshold_out_chk
`default_nettype wire

// ---- tb/tto_bus_mon.sv ----
// Purpose: far-side bus device receiving the 1-bit output object
// Assumes: one telegram per tx_valid pulse
// Notes:   counts telegrams and keeps the last value received
`default_nettype none
module tto_bus_mon (
   input  wire logic        core_clk,
   input  wire logic        srst,
   input  wire logic        tx_valid,
   input  wire logic        tx_value,
   output var  logic [15:0] tel_count,
   output var  logic        tel_last
);
   timeunit 1ns;
   timeprecision 1ps;
   always_ff @(posedge core_clk) begin
      if (srst) begin
         tel_count <= 16'h0000;
         tel_last  <= 1'b0;
      end else if (tx_valid) begin
         tel_count <= tel_count + 16'h0001;
         tel_last  <= tx_value;
      end
   end
endmodule : tto_bus_mon
`default_nettype wire

// ---- tb/tto_threshold_out_tb.sv ----
// Purpose: self-checking bench for the threshold output stage
// Assumes: one-second tick shortened to TICK cycles
// Notes:   register tasks speak the plain strobe port
`include "tto_consts.svh"
`default_nettype none
module tto_threshold_out_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import tto_pkg::*;
   localparam int TICK = 10;
   logic        core_clk = 1'b0;
   logic        srst = 1'b1;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   tto_addr_t   reg_addr = 4'h0;
   tto_word_t   reg_wdata = 16'h0000;
   tto_word_t   reg_rdata;
   tto_word_t   rd_val;
   logic [15:0] lux_value = 16'h0000;
   logic [15:0] tel_count;
   logic        tx_valid;
   logic        tx_value;
   logic        tel_last;
   logic        acc_exp;
   int          num_errors = 0;
   int          samples_checked = 0;
   int          gap;
   int          hi_a[12] = '{1, 0, 0, 1, 1, 0, 2, 2, 2, 2, 0, 1};
   int          lo_a[12] = '{0, 1, 1, 0, 2, 2, 1, 0, 0, 1, 2, 2};
   always #4 core_clk = ~core_clk;
   tto_threshold_out #(.TICK_CYCLES(TICK)) dut (.core_clk, .srst, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .lux_value, .tx_valid, .tx_value);
   tto_bus_mon u_mon (.core_clk, .srst, .tx_valid, .tx_value, .tel_count, .tel_last);
   task automatic stop_test();
      $display("errors %0d checked %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : stop_test
   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s exp %h got %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(tto_addr_t a, tto_word_t d);
      @(posedge core_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rdc(tto_addr_t a, tto_word_t e);
      @(posedge core_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      rd_val = reg_rdata;
      chk("reg", e, rd_val);
   endtask : rdc
   task automatic lux(logic [15:0] v);
      @(posedge core_clk);
      lux_value <= v;
   endtask : lux
   task automatic wait_tel(logic e, int lim);
      for (gap = 0; gap < lim && tx_valid !== 1'b1; gap++) begin
         @(posedge core_clk);
         #1;
      end
      chk("tx_valid", 16'h0001, {15'h0, tx_valid});
      if (tx_valid !== 1'b1) stop_test();
      @(posedge core_clk);
      #1;
      chk("telegram", {15'h0, e}, {15'h0, tel_last});
   endtask : wait_tel
   task automatic no_tel(logic e, int c);
      logic [15:0] cnt0;
      #1;
      cnt0 = tel_count;
      repeat (c) @(posedge core_clk);
      #1;
      chk("tel_count", cnt0, tel_count);
      chk("tx_value", {15'h0, e}, {15'h0, tx_value});
   endtask : no_tel
   task automatic mode_step(int m, logic [15:0] v, int act);
      tto_word_t st;
      lux(v);
      repeat (6) @(posedge core_clk);
      if (act != 2) acc_exp = act[0];
      st = 16'h0000;
      st[4] = (act == 2);
      st[1] = (v < 16'h0064) ? m[1] : !m[1];
      st[0] = acc_exp;
      rdc(`TTO_REG_STATUS, st);
      chk("accepted", {15'h0, acc_exp}, {15'h0, rd_val[0]});
      chk("muted", {15'h0, act == 2}, {15'h0, rd_val[4]});
   endtask : mode_step
   initial begin
      #200000;
      $display("MISMATCH watchdog exp done got hang");
      num_errors++;
      stop_test();
   end
   initial begin
      repeat (12) @(posedge core_clk);
      srst <= 1'b0;
      for (int a = 0; a < 5; a++) rdc(tto_addr_t'(a), 16'h0000);
      rdc(4'hA, 16'h0000);
      wr(`TTO_REG_LEVEL, 16'h001F);
      rdc(`TTO_REG_LEVEL, 16'h001A);
      wr(`TTO_REG_CYCLE, 16'h00C8);
      rdc(`TTO_REG_CYCLE, 16'h0078);
      wr(`TTO_REG_CYCLE, 16'h0000);
      wr(`TTO_REG_HYST, 16'h000F);
      rdc(`TTO_REG_HYST, 16'h000F);
      wr(`TTO_REG_HYST, 16'h0003);
      wr(`TTO_REG_LEVEL, 16'h0004);
      rdc(`TTO_REG_EXT16, 16'h0064);
      $display("registers done");
      wr(`TTO_REG_CTRL, 16'h0081);
      lux(16'h0032);
      lux(16'h0096);
      wait_tel(1'b1, 20);
      lux(16'h005A);
      no_tel(1'b1, 20);
      lux(16'h0046);
      wait_tel(1'b0, 20);
      wr(`TTO_REG_CTRL, 16'h0085);
      wait_tel(1'b1, 20);
      lux(16'h0078);
      no_tel(1'b1, 20);
      lux(16'h0082);
      wait_tel(1'b0, 20);
      acc_exp = 1'b0;
      for (int m = 0; m < 12; m++) begin
         wr(`TTO_REG_CTRL, 16'h0081 | tto_word_t'(m << 1));
         // new mode first settles at the previous high lux
         if (hi_a[m] != 2) acc_exp = hi_a[m][0];
         mode_step(m, 16'h0032, lo_a[m]);
         mode_step(m, 16'h0096, hi_a[m]);
      end
      wr(`TTO_REG_CTRL, 16'h0080);
      lux(16'h0032);
      lux(16'h0096);
      no_tel(1'b0, 20);
      $display("modes done");
      wr(`TTO_REG_DELAY, 16'h0022);
      wr(`TTO_REG_CTRL, 16'h0081);
      lux(16'h0032);
      repeat (6) @(posedge core_clk);
      lux(16'h0096);
      repeat (5) @(posedge core_clk);
      lux(16'h0032);
      no_tel(1'b0, 50);
      lux(16'h0096);
      no_tel(1'b0, 18);
      rdc(`TTO_REG_STATUS, 16'h0006);
      wait_tel(1'b1, 20);
      lux(16'h0032);
      no_tel(1'b1, 18);
      rdc(`TTO_REG_STATUS, 16'h0009);
      wait_tel(1'b0, 20);
      wr(`TTO_REG_DELAY, 16'h0000);
      $display("delays done");
      wr(`TTO_REG_CTRL, 16'h0001);
      lux(16'h0096);
      no_tel(1'b1, 40);
      wr(`TTO_REG_CYCLE, 16'h0001);
      wait_tel(1'b1, 120);
      wait_tel(1'b1, 120);
      chk("period", 16'd99, 16'(gap));
      wr(`TTO_REG_CTRL, 16'h0011);
      no_tel(1'b1, 250);
      lux(16'h0032);
      wait_tel(1'b0, 120);
      wr(`TTO_REG_CYCLE, 16'h0000);
      $display("cyclic done");
      wr(`TTO_REG_CTRL, 16'h0021);
      wr(`TTO_REG_EXT16, 16'h012C);
      rdc(`TTO_REG_EXT16, 16'h012C);
      rdc(`TTO_REG_STATUS, 16'h0020);
      wr(`TTO_REG_CTRL, 16'h0041);
      rdc(`TTO_REG_EXT16, 16'h0064);
      wr(`TTO_REG_EXT16, 16'h0200);
      rdc(`TTO_REG_EXT16, 16'h0064);
      wr(`TTO_REG_EXT8, 16'h0032);
      rdc(`TTO_REG_EXT16, 16'h0151);
      wr(`TTO_REG_CTRL, 16'h0001);
      rdc(`TTO_REG_EXT16, 16'h0064);
      $display("external done");
      @(posedge core_clk);
      srst <= 1'b1;
      repeat (3) @(posedge core_clk);
      srst <= 1'b0;
      rdc(`TTO_REG_CTRL, 16'h0000);
      rdc(`TTO_REG_STATUS, 16'h0000);
      $display("reset done");
      stop_test();
   end
endmodule : tto_threshold_out_tb
bind tto_threshold_out tto_threshold_out_chk u_chk (.core_clk, .srst, .reg_addr, .reg_wdata,
   .reg_wr, .reg_rd, .reg_rdata, .lux_value, .tx_valid, .tx_value);
`default_nettype wire
